// file: cctl_engine_model.sv
// Engine-side stand-in that drives the status inputs of the control block
`default_nettype none
module cctl_engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] pattern,
  output logic device_idle,
  output logic frame_brs,
  output logic proto_exception,
  output logic engine_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // Levels move only on the clock, as a real engine's would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {device_idle, frame_brs, proto_exception, engine_busy} <= 4'h0;
    end else begin
      {device_idle, frame_brs, proto_exception, engine_busy} <= pattern;
    end
  end
endmodule : cctl_engine_model
`default_nettype wire

// file: cctl_pkg.sv
// Package: register map, field layout and reset values of the control block
`default_nettype none
package cctl_pkg;
  localparam logic [3:0] ADDR_CTRL_LOW = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int POS_ON = 15;
  localparam int POS_HALT = 13;
  localparam int POS_RATE = 12;
  localparam int POS_ACTIVE = 11;
  localparam int POS_WFT = 9;
  localparam int POS_WFIL = 8;
  localparam int POS_CLK = 7;
  localparam int POS_PXE = 6;
  localparam int POS_ISO = 5;
  localparam int POS_DN = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0760;
  localparam logic [15:0] CTRL_WMASK = 16'hB7FF;
  localparam logic [15:0] CFG_ONLY_MASK = 16'h01E0;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [2:0] MODE_RESET = 3'h4;
  localparam logic [4:0] DN_MAX_VALID = 5'h12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic module_on;
    logic halt_when_idle;
    logic rate_switch_off;
    logic [1:0] wake_filter_time;
    logic wake_filter_on;
    logic module_clock_pick;
    logic proto_exception_off;
    logic iso_checksum_on;
    logic [4:0] filter_data_bit_count;
  } cctl_cfg_t;
endpackage : cctl_pkg
`default_nettype wire

// file: cctl_top.sv
// Low control register of the CAN FD module with its AXI4-Lite slave
`default_nettype none
module cctl_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic device_idle,
  input wire logic frame_brs,
  input wire logic proto_exception,
  input wire logic engine_busy,
  output logic module_enable,
  output logic module_run,
  output logic data_rate_switch,
  output logic form_error_on_pxe,
  output logic pxe_detect_on,
  output logic [1:0] wake_filter_time,
  output logic wake_filter_on,
  output logic module_clock_pick,
  output logic iso_checksum_on,
  output logic [4:0] filter_data_bit_count,
  output logic filter_data_bits_valid
);
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [2:0] mode_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic [15:0] wmask;
  logic cfg_mode;
  cctl_pkg::cctl_cfg_t cfg;
  logic active;

  // Expand byte strobes to a 16-bit lane mask
  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  // Address and data are latched independently, either order
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end
  end

  // Write response one cycle after both halves are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cctl_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_r == cctl_pkg::ADDR_STATUS)
        ? cctl_pkg::RESP_SLVERR : cctl_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Mode decided by the value currently held, not the one being written
  assign cfg_mode = (mode_r == cctl_pkg::MODE_CONFIG);

  // Configuration-only bits drop out of the mask outside config mode
  always_comb begin
    wmask = lane_mask(wstrb_r) & cctl_pkg::CTRL_WMASK;
    if (!cfg_mode) begin
      wmask = wmask & ~cctl_pkg::CFG_ONLY_MASK;
    end
    ctrl_nxt = (ctrl_r & ~wmask) | (wdata_r[15:0] & wmask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= cctl_pkg::CTRL_RESET;
    end else if (wr_go && awaddr_r == cctl_pkg::ADDR_CTRL_LOW) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Requested operating mode; starts in configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= cctl_pkg::MODE_RESET;
    end else if (wr_go && awaddr_r == cctl_pkg::ADDR_MODE && wstrb_r[0]) begin
      mode_r <= wdata_r[2:0];
    end
  end

  assign cfg = cctl_pkg::cctl_cfg_t'({ctrl_r[15], ctrl_r[13:12],
                                      ctrl_r[10:0]});
  assign active = cfg.module_on && engine_busy;

  // Read channel; one read outstanding, data registered
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cctl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= cctl_pkg::RESP_OKAY;
      case (s_axi_araddr)
        cctl_pkg::ADDR_CTRL_LOW: begin
          s_axi_rdata <= {16'h0000, ctrl_r[15:12], active,
                          ctrl_r[10:0]};
        end
        cctl_pkg::ADDR_MODE: begin
          s_axi_rdata <= {29'h0000_0000, mode_r};
        end
        cctl_pkg::ADDR_STATUS: begin
          s_axi_rdata <= {31'h0000_0000, active};
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= cctl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control outputs steering the protocol engine
  assign module_enable = cfg.module_on;
  // Idle halts only when asked to
  assign module_run = cfg.module_on
    && !(device_idle && cfg.halt_when_idle);
  assign data_rate_switch = frame_brs && !cfg.rate_switch_off;
  assign form_error_on_pxe = proto_exception
    && cfg.proto_exception_off;
  assign pxe_detect_on = !cfg.proto_exception_off;
  assign wake_filter_time = cfg.wake_filter_time;
  assign wake_filter_on = cfg.wake_filter_on;
  assign module_clock_pick = cfg.module_clock_pick;
  assign iso_checksum_on = cfg.iso_checksum_on;
  // Codes above eighteen select nothing
  assign filter_data_bit_count = cfg.filter_data_bit_count;
  assign filter_data_bits_valid =
    cfg.filter_data_bit_count <= cctl_pkg::DN_MAX_VALID;

  // Checks
  a_cfg_write_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && awaddr_r == cctl_pkg::ADDR_CTRL_LOW && !cfg_mode)
    |=> ((ctrl_r & cctl_pkg::CFG_ONLY_MASK)
         == ($past(ctrl_r) & cctl_pkg::CFG_ONLY_MASK)))
    else $error("config-only field changed outside config mode");
  a_cfg_write_take: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && awaddr_r == cctl_pkg::ADDR_CTRL_LOW && cfg_mode
     && wstrb_r[0]) |=> (ctrl_r[7:5] == $past(wdata_r[7:5])))
    else $error("config write not stored");
  a_enable_out: assert property (@(posedge aclk) disable iff (!aresetn)
    module_enable == ctrl_r[15])
    else $error("enable output mismatch");
  a_idle_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    (device_idle && ctrl_r[13]) |-> !module_run)
    else $error("module ran in idle");
  a_rate_switch: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r[12] |-> !data_rate_switch)
    else $error("rate switched while disabled");
  a_busy_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready
     && s_axi_araddr == cctl_pkg::ADDR_CTRL_LOW)
    |=> s_axi_rvalid && s_axi_rdata[11] == $past(active))
    else $error("busy flag mismatch");
  a_pxe_form: assert property (@(posedge aclk) disable iff (!aresetn)
    (proto_exception && ctrl_r[6]) |-> form_error_on_pxe)
    else $error("exception not form error");
  a_dn_valid: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r[4:0] > 5'h12) |-> !filter_data_bits_valid)
    else $error("invalid count accepted");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid ##0 !aw_hold_r)
    else $error("write response missing");

  // Output decode checks; the module clock pick output has none
  a_run_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_r[15] |-> !module_run)
    else $error("module ran while disabled");

  a_rate_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_r[12] && frame_brs) |-> data_rate_switch)
    else $error("per-message rate switch dropped");

  a_pxe_detect: assert property (@(posedge aclk) disable iff (!aresetn)
    pxe_detect_on != ctrl_r[6])
    else $error("exception detect enable mismatch");

  a_wake_time: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_filter_time == ctrl_r[10:9])
    else $error("wake filter time mismatch");

  a_wake_filter: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_filter_on == ctrl_r[8])
    else $error("wake filter enable mismatch");

  a_iso_crc: assert property (@(posedge aclk) disable iff (!aresetn)
    iso_checksum_on == ctrl_r[5])
    else $error("checksum mode mismatch");

  a_dn_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    filter_data_bit_count == ctrl_r[4:0])
    else $error("filter bit count mismatch");

  // Reserved and busy positions are never stored
  a_fixed_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_r[14] && !ctrl_r[11])
    else $error("read-only control bit stored");

  // A refused write to the status word must leave control untouched
  a_status_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && awaddr_r == cctl_pkg::ADDR_STATUS)
    |=> ctrl_r == $past(ctrl_r))
    else $error("status write changed control");

  // Answers stand until the master takes them
  a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready)
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");

  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped early");

  a_ar_accept: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer missing");

  // Scenarios worth seeing at least once
  c_rate_off: cover property (@(posedge aclk) disable iff (!aresetn)
    frame_brs && ctrl_r[12]);
  c_cfg_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_go && cfg_mode && awaddr_r == cctl_pkg::ADDR_CTRL_LOW);
  c_locked_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_go && !cfg_mode && awaddr_r == cctl_pkg::ADDR_CTRL_LOW);
  c_idle_halt: cover property (@(posedge aclk) disable iff (!aresetn)
    device_idle && ctrl_r[13] && ctrl_r[15]);
  c_read_busy: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rdata[11]);
endmodule : cctl_top
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the CAN control block over AXI4-Lite
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, idle, brs, pxe, busy;
  logic [3:0] awaddr, araddr, pat;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  wire logic [15:0] seen;
  logic [15:0] shadow, seed, d;
  logic [3:0] strb, sb;
  logic [2:0] mode;
  logic [15:0] corner [4] = '{16'hFFFF, 16'h0012, 16'h0013, 16'h0000};
  int err_total, cmp_count, i;
  cctl_engine_model eng (.aclk(aclk), .aresetn(aresetn), .pattern(pat),
    .device_idle(idle), .frame_brs(brs), .proto_exception(pxe),
    .engine_busy(busy));
  cctl_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .device_idle(idle), .frame_brs(brs),
    .proto_exception(pxe), .engine_busy(busy), .module_enable(seen[15]),
    .module_run(seen[14]), .data_rate_switch(seen[13]),
    .form_error_on_pxe(seen[12]), .pxe_detect_on(seen[11]),
    .wake_filter_time(seen[10:9]), .wake_filter_on(seen[8]),
    .module_clock_pick(seen[7]), .iso_checksum_on(seen[6]),
    .filter_data_bit_count(seen[5:1]), .filter_data_bits_valid(seen[0]));
  // Repeatable pseudo-random source
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Expected side outputs from the stored control word and engine levels
  function automatic logic [15:0] exp_out(input logic [15:0] s);
    return {s[15], s[15] & !(idle & s[13]), brs & !s[12], pxe & s[6],
      !s[6], s[10:9], s[8], s[7], s[5], s[4:0], s[4:0] <= 5'h12};
  endfunction : exp_out
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic close_out(input bit hang);
    if (hang) err_total++;
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [15:0] v);
    int n;
    logic aw, w, b;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {~v, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
    if (n == 50) close_out(1'b1);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    int n;
    logic ar, r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar = arvalid & arready;
      r = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (r) break;
    end
    rready <= 1'b0;
    if (n == 50) close_out(1'b1);
  endtask : axi_rd
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Main sequence: reset values, refusals, then random and corner words
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, pat, wdata} = 44'h0;
    strb = 4'hF;
    shadow = 16'h0760;
    mode = 3'h4;
    seed = 16'h0010;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(4'h0);
    chk(rd, 32'h00000760);
    axi_wr(4'h8, 16'hFFFF);
    chk(resp, 2'h2);
    axi_rd(4'hC);
    chk({30'h0, resp}, 32'h2);
    chk(rd, 32'h0);
    for (i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      pat <= seed[3:0];
      // Lock window: every other group of four runs outside configuration
      if (i % 8 == 0 || i % 8 == 4) begin
        mode = (i % 8 == 0) ? 3'h4 : {1'b0, seed[5:4]};
        axi_wr(4'h4, {13'h0, mode});
        axi_rd(4'h4);
        chk(rd, {29'h0, mode});
      end
      // Now and then only the low byte lane is written
      sb = (i % 5 == 3) ? 4'h1 : 4'hF;
      strb <= sb;
      d = (i < 4) ? corner[i] : seed;
      axi_wr(4'h0, d);
      d = 16'hB7FF & ((mode == 3'h4) ? 16'hFFFF : 16'hFE1F)
        & {{8{sb[1]}}, {8{sb[0]}}};
      shadow = (shadow & ~d) | (seed & d);
      if (i < 4) shadow = (shadow & ~d) | (corner[i] & d);
      axi_rd(4'h0);
      chk(rd, {16'h0, shadow[15:12], shadow[15] & busy, shadow[10:0]});
      @(negedge aclk);
      chk(seen, exp_out(shadow));
    end
    close_out(1'b0);
  end
endmodule : tb_top
`default_nettype wire
